// file: inc/acsp_pkg.sv
`default_nettype none
package acsp_pkg;
  localparam int unsigned CMD_BITS   = 8;
  localparam int unsigned DATA_BITS  = 16;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned CNT_W      = 5;
  localparam int unsigned ADDR_W     = 6;

  localparam logic [ADDR_W-1:0] REG_STATUS = 6'h00;
  localparam logic [ADDR_W-1:0] REG_MODE   = 6'h01;
  localparam logic [ADDR_W-1:0] REG_DATA   = 6'h04;

  localparam int unsigned CMD_RD_BIT  = 6;
  localparam int unsigned CLKSEL_LSB  = 2;
  localparam logic [15:0] MODE_RST    = 16'h0000;
  localparam logic [15:0] DATA_RST    = 16'h0000;

  localparam logic [1:0] CLK_INT_NOOUT = 2'h0;
  localparam logic [1:0] CLK_INT_OUT   = 2'h1;
  localparam logic [1:0] CLK_EXT_IN    = 2'h2;
  localparam logic [1:0] CLK_CRYSTAL   = 2'h3;

  localparam logic [2:0] SYNC_RST_HI = 3'h7;
  localparam logic [2:0] SYNC_RST_LO = 3'h0;

  typedef enum logic [1:0] {
    ACSP_CMD   = 2'b01,
    ACSP_WDATA = 2'b10
  } acsp_wr_t;

  typedef enum logic [2:0] {
    ACSP_S_CMD   = 3'b001,
    ACSP_S_WDATA = 3'b010,
    ACSP_S_RDATA = 3'b100
  } acsp_state_t;
endpackage
`default_nettype wire

// file: verilog/acsp_serial_port.sv
`default_nettype none

module acsp_fifo #(
  parameter int unsigned W = 16,
  parameter int unsigned D = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output var  logic         in_ready,
  output var  logic [W-1:0] out_data,
  output var  logic         out_valid,
  input  wire logic         out_ready
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic [AW:0]   cnt_d;
  logic          push;
  logic          pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_q];
  assign out_valid = (cnt_q != '0);
  assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q     <= '0;
      rd_q     <= '0;
      cnt_q    <= '0;
      in_ready <= 1'b1;
    end else begin
      wr_q     <= wr_q + AW'(push);
      rd_q     <= rd_q + AW'(pop);
      cnt_q    <= cnt_d;
      in_ready <= (cnt_d != (AW+1)'(D));
    end
  end
endmodule

module acsp_serial_port
  import acsp_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 cs_n,
  input  wire logic                 sclk,
  input  wire logic                 din,
  output var  logic                 dout_o,
  output var  logic                 dout_oe,
  input  wire logic [DATA_BITS-1:0] conv_data,
  input  wire logic                 conv_valid,
  output var  logic                 conv_ready,
  output var  logic                 int_osc_en_q,
  output var  logic                 crystal_pin_b_clock_io_oe_q,
  output var  logic                 ext_clk_en_q,
  output var  logic                 crystal_osc_en_q
);
  logic [2:0]           cs_sync_q;
  logic [2:0]           sclk_sync_q;
  logic [2:0]           din_sync_q;
  logic                 cs_lvl_q;
  logic                 sclk_lvl_q;
  logic                 din_lvl_q;
  logic                 sclk_rise;
  logic                 sclk_fall;
  acsp_state_t          state_q;
  logic [CNT_W-1:0]     bit_q;
  logic [CMD_BITS-1:0]  cmd_q;
  logic [DATA_BITS-1:0] in_sh_q;
  logic [DATA_BITS-1:0] out_sh_q;
  logic [DATA_BITS-1:0] mode_q;
  logic [DATA_BITS-1:0] data_q;
  logic                 rdy_low_q;
  logic                 busy;
  logic                 cmd_done;
  logic                 data_done;
  logic [CMD_BITS-1:0]  cmd_next;
  logic [DATA_BITS-1:0] in_next;
  logic [DATA_BITS-1:0] rd_mux;
  logic [DATA_BITS-1:0] fifo_data;
  logic                 fifo_valid;
  logic                 fifo_pop;
  logic [1:0]           clk_sel;

  acsp_fifo #(.W(DATA_BITS), .D(FIFO_DEPTH)) u_fifo (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .in_data   (conv_data),
    .in_valid  (conv_valid),
    .in_ready  (conv_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // Pins are asynchronous; a level is only accepted once stages two and three agree.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_q   <= SYNC_RST_HI;
      sclk_sync_q <= SYNC_RST_HI;
      din_sync_q  <= SYNC_RST_LO;
      cs_lvl_q    <= 1'b1;
      sclk_lvl_q  <= 1'b1;
      din_lvl_q   <= 1'b0;
    end else begin
      cs_sync_q   <= {cs_sync_q[1:0], cs_n};
      sclk_sync_q <= {sclk_sync_q[1:0], sclk};
      din_sync_q  <= {din_sync_q[1:0], din};
      if (cs_sync_q[1] == cs_sync_q[2]) cs_lvl_q <= cs_sync_q[2];
      if (sclk_sync_q[1] == sclk_sync_q[2]) sclk_lvl_q <= sclk_sync_q[2];
      if (din_sync_q[1] == din_sync_q[2]) din_lvl_q <= din_sync_q[2];
    end
  end

  // Edges are qualified by the select so a deselected device ignores the bus.
  assign sclk_rise = !cs_lvl_q && (sclk_sync_q[1] == sclk_sync_q[2])
                     && sclk_sync_q[2] && !sclk_lvl_q;
  assign sclk_fall = !cs_lvl_q && (sclk_sync_q[1] == sclk_sync_q[2])
                     && !sclk_sync_q[2] && sclk_lvl_q;

  assign busy      = (state_q != ACSP_S_CMD) || (bit_q != '0);
  assign cmd_next  = {cmd_q[CMD_BITS-2:0], din_lvl_q};
  assign in_next   = {in_sh_q[DATA_BITS-2:0], din_lvl_q};
  assign cmd_done  = sclk_rise && (state_q == ACSP_S_CMD)
                     && (bit_q == CNT_W'(CMD_BITS-1));
  assign data_done = sclk_rise && (state_q != ACSP_S_CMD)
                     && (bit_q == CNT_W'(DATA_BITS-1));
  assign clk_sel   = mode_q[CLKSEL_LSB+1:CLKSEL_LSB];
  // Results are only taken between transfers, so a read never sees a word change mid-shift.
  assign fifo_pop  = fifo_valid && !busy && !rdy_low_q;

  always_comb begin
    unique case (cmd_next[ADDR_W-1:0])
      REG_STATUS: rd_mux = {{(DATA_BITS-3){1'b0}}, fifo_valid, !conv_ready, rdy_low_q};
      REG_MODE:   rd_mux = mode_q;
      REG_DATA:   rd_mux = data_q;
      default:    rd_mux = '0;
    endcase
  end

  // Select high aborts any frame; with select tied low frames simply follow each other.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ACSP_S_CMD;
      bit_q   <= '0;
    end else if (cs_lvl_q) begin
      state_q <= ACSP_S_CMD;
      bit_q   <= '0;
    end else if (cmd_done) begin
      state_q <= cmd_next[CMD_RD_BIT] ? ACSP_S_RDATA : ACSP_S_WDATA;
      bit_q   <= '0;
    end else if (data_done) begin
      state_q <= ACSP_S_CMD;
      bit_q   <= '0;
    end else if (sclk_rise) begin
      bit_q   <= bit_q + CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q   <= '0;
      in_sh_q <= '0;
    end else if (sclk_rise) begin
      if (state_q == ACSP_S_CMD) cmd_q <= cmd_next;
      else in_sh_q <= in_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= MODE_RST;
    end else if (data_done && state_q == ACSP_S_WDATA
                 && cmd_q[ADDR_W-1:0] == REG_MODE) begin
      mode_q <= in_next;
    end
  end

  // A new result first lets ready go high for a cycle when the old one was never read.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_q    <= DATA_RST;
      rdy_low_q <= 1'b0;
    end else if (data_done && state_q == ACSP_S_RDATA
                 && cmd_q[ADDR_W-1:0] == REG_DATA) begin
      rdy_low_q <= 1'b0;
    end else if (fifo_valid && !busy && rdy_low_q) begin
      rdy_low_q <= 1'b0;
    end else if (fifo_pop) begin
      data_q    <= fifo_data;
      rdy_low_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_sh_q <= '0;
      dout_o   <= 1'b1;
      dout_oe  <= 1'b0;
    end else begin
      dout_oe <= !cs_lvl_q;
      if (cmd_done && cmd_next[CMD_RD_BIT]) begin
        out_sh_q <= rd_mux;
      end else if (sclk_fall && state_q == ACSP_S_RDATA) begin
        dout_o   <= out_sh_q[DATA_BITS-1];
        out_sh_q <= {out_sh_q[DATA_BITS-2:0], 1'b0};
      end else if (!busy) begin
        dout_o   <= !rdy_low_q;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_osc_en_q                <= 1'b1;
      crystal_pin_b_clock_io_oe_q <= 1'b0;
      ext_clk_en_q                <= 1'b0;
      crystal_osc_en_q            <= 1'b0;
    end else begin
      int_osc_en_q                <= (clk_sel == CLK_INT_NOOUT)
                                     || (clk_sel == CLK_INT_OUT);
      crystal_pin_b_clock_io_oe_q <= (clk_sel == CLK_INT_OUT);
      ext_clk_en_q                <= (clk_sel == CLK_EXT_IN);
      crystal_osc_en_q            <= (clk_sel == CLK_CRYSTAL);
    end
  end

  clk_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_sel == CLK_INT_OUT) |=> crystal_pin_b_clock_io_oe_q && int_osc_en_q)
    else $error("clock output not enabled for internal source with output");
  clk_ext_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_sel == CLK_EXT_IN) |=> ext_clk_en_q && !crystal_pin_b_clock_io_oe_q)
    else $error("external clock mode drives the clock pin");
  fall_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == ACSP_S_RDATA && !sclk_fall && !cmd_done) |=> $stable(dout_o))
    else $error("data bit changed without a serial clock fall");
  cs_hiz_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cs_lvl_q |=> !dout_oe)
    else $error("data pin driven while deselected");
  rdy_show_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!busy && !cs_lvl_q && rdy_low_q && !fifo_valid) |=> !dout_o)
    else $error("ready not shown low on idle data pin");
  // A frame starting in the clearing cycle defers the load to the next idle gap.
  rdy_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rdy_low_q && fifo_valid && !busy && !sclk_rise)
      |=> !rdy_low_q ##1 (rdy_low_q && data_q == $past(fifo_data)))
    else $error("unread result overwritten without ready going high");
  rise_cap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sclk_rise && state_q != ACSP_S_CMD) |=> in_sh_q[0] == $past(din_lvl_q))
    else $error("input bit not captured on rising edge");
  mode_wr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (data_done && state_q == ACSP_S_WDATA && cmd_q[ADDR_W-1:0] == REG_MODE)
      |=> mode_q == $past(in_next))
    else $error("mode register write lost");
  shift_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cmd_done && cmd_next[CMD_RD_BIT]) |=> out_sh_q == $past(rd_mux))
    else $error("output shifter not loaded from addressed register");
  desel_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cs_lvl_q |=> (state_q == ACSP_S_CMD && bit_q == '0))
    else $error("frame state kept while deselected");
endmodule
`default_nettype wire

// file: test/acsp_host_model.sv
`default_nettype none
module acsp_host_model (
  input  wire logic ref_clk,
  input  wire logic dout,
  output var  logic cs_n,
  output var  logic sclk,
  output var  logic din
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din  = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Mode 0 frames with select, 1 leaves select low, 2 keeps it high, 3 stops after the command.
  task automatic xfer(input int mode, input logic [7:0] cmd, input logic [15:0] wdata,
                      output logic [15:0] rdata);
    logic [23:0] word;
    word  = {cmd, wdata};
    rdata = 16'h0000;
    @(posedge ref_clk);
    cs_n <= (mode == 2);
    wait_clk(4);
    for (int i = 23; i >= 0; i--) begin
      if (mode == 3 && i == 15) begin
        return;
      end
      sclk <= 1'b0;
      din  <= word[i];
      wait_clk(4);
      sclk <= 1'b1;
      wait_clk(4);
      // Sampled late in the high phase, because the answer trails the fall by several cycles.
      if (i < 16) begin
        rdata[i] = dout;
      end
    end
    din <= ~word[0];
    if (mode != 1) begin
      cs_n <= 1'b1;
    end
  endtask

  task automatic release_cs();
    @(posedge ref_clk);
    cs_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// file: test/test_adc_serial_port_clock_select.sv
`default_nettype none
module test_adc_serial_port_clock_select;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIMIT = 20000;
  logic        ref_clk;
  logic        rst_n;
  logic [15:0] conv_data;
  logic        conv_valid;
  wire logic   cs_n, sclk, din, dout_o, dout_oe, conv_ready, osc, clkio, ext, xtal;
  wire logic   dout_w;
  int          n_mismatch, comparisons, cycles;
  logic [15:0] rd;
  logic        hi;
  logic        prev;
  logic [5:0]  rows [4] = '{6'h1C, 6'h22, 6'h31, 6'h08};

  assign dout_w = dout_oe ? dout_o : 1'bz;

  acsp_serial_port DUT (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .din(din),
    .dout_o(dout_o), .dout_oe(dout_oe), .conv_data(conv_data), .conv_valid(conv_valid),
    .conv_ready(conv_ready), .int_osc_en_q(osc), .crystal_pin_b_clock_io_oe_q(clkio),
    .ext_clk_en_q(ext), .crystal_osc_en_q(xtal));
  acsp_host_model host (.ref_clk(ref_clk), .dout(dout_w), .cs_n(cs_n), .sclk(sclk), .din(din));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic neg(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Valid stays high on return, so chained pushes never assign it twice in one step.
  task automatic push(input logic [15:0] w);
    conv_data  <= w;
    conv_valid <= 1'b1;
    neg(1);
    while (conv_ready !== 1'b1) neg(1);
    @(posedge ref_clk);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      results();
    end
  end

  initial begin
    cycles     = 0;
    rst_n      = 1'b0;
    conv_data  = 16'h0000;
    conv_valid = 1'b0;
    neg(10);
    check("dout_oe", 16'(dout_oe), 16'h0000);
    check("clk_sel", 16'({osc, clkio, ext, xtal}), 16'h0008);
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    neg(6);
    check("dout_oe", 16'(dout_oe), 16'h0000);
    $display("reset test done");
    foreach (rows[i]) begin
      host.xfer(0, 8'h01, {12'h000, rows[i][5:4], 2'b00}, rd);
      neg(8);
      check("clk_sel", 16'({osc, clkio, ext, xtal}), 16'(rows[i][3:0]));
      host.xfer(0, 8'h41, 16'h0000, rd);
      check("mode", rd, {12'h000, rows[i][5:4], 2'b00});
    end
    host.xfer(0, 8'h7F, 16'h0000, rd);
    check("unmapped", rd, 16'h0000);
    host.xfer(2, 8'h01, 16'h000C, rd);
    neg(8);
    check("clk_sel", 16'({osc, clkio, ext, xtal}), 16'h0008);
    $display("register tests done");
    @(posedge ref_clk);
    push(16'hA5C3);
    conv_valid <= 1'b0;
    neg(12);
    host.xfer(1, 8'h40, 16'h0000, rd);
    check("status", rd, 16'h0001);
    neg(8);
    check("ready", 16'({dout_oe, dout_o}), 16'h0002);
    host.xfer(1, 8'h44, 16'h0000, rd);
    check("data", rd, 16'hA5C3);
    neg(8);
    check("ready", 16'(dout_o), 16'h0001);
    @(posedge ref_clk);
    push(16'h1111);
    conv_valid <= 1'b0;
    // The host treats a falling ready level on the shared pin as its interrupt.
    hi   = 1'b0;
    prev = dout_w;
    repeat (12) begin
      neg(1);
      if (prev === 1'b1 && dout_w === 1'b0) hi = 1'b1;
      prev = dout_w;
    end
    check("ready_fall", 16'(hi), 16'h0001);
    check("ready", 16'(dout_o), 16'h0000);
    @(posedge ref_clk);
    push(16'h2222);
    conv_valid <= 1'b0;
    hi = 1'b0;
    repeat (20) begin
      neg(1);
      hi = hi | dout_o;
    end
    check("ready_pulse", 16'(hi), 16'h0001);
    host.xfer(0, 8'h44, 16'h0000, rd);
    check("data", rd, 16'h2222);
    $display("ready tests done");
    host.xfer(3, 8'h44, 16'h0000, rd);
    for (int i = 0; i < 16; i++) push(16'h3000 + 16'(i));
    conv_valid <= 1'b0;
    neg(2);
    check("conv_ready", 16'(conv_ready), 16'h0000);
    host.release_cs();
    neg(60);
    host.xfer(0, 8'h40, 16'h0000, rd);
    check("status", rd, 16'h0001);
    host.xfer(0, 8'h44, 16'h0000, rd);
    check("data", rd, 16'h300F);
    $display("buffer test done");
    results();
  end
endmodule
`default_nettype wire
